// ### hdl/twbs_params.svh
`ifndef TWBS_PARAMS_SVH
`define TWBS_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define TWBS_ADDR_CTRL 8'h9a
`define TWBS_ADDR_DATA 8'h9b
`define TWBS_ADDR_GM   8'h9c
`define TWBS_ADDR_STAT 8'h9d
`define TWBS_ADDR_SRST 8'h9e

// ----------------------------------------
// reset values
// ----------------------------------------
`define TWBS_RST_STAT  8'h00
`define TWBS_RST_SRST  8'h80

// ----------------------------------------
// field positions
// ----------------------------------------
`define TWBS_CTRL_START 7
`define TWBS_CTRL_STOP  6
`define TWBS_CTRL_ACK   5
`define TWBS_CTRL_FAST  3
`define TWBS_CTRL_MSTR  2
`define TWBS_CTRL_SCLS  1
`define TWBS_CTRL_FILEN 0
`define TWBS_GM_EN      7
`define TWBS_SA_EN      7

// ----------------------------------------
// timing
// ----------------------------------------
`define TWBS_CLK_HZ  50000000
`define TWBS_STD_HZ  100000
`define TWBS_FAST_HZ 400000
`define TWBS_DIV_MIN 3
`define TWBS_DIV_STD ((`TWBS_CLK_HZ + 2*`TWBS_STD_HZ - 1) / (2*`TWBS_STD_HZ) - 1)
`define TWBS_DIV_FAST ((`TWBS_CLK_HZ + 2*`TWBS_FAST_HZ - 1) / (2*`TWBS_FAST_HZ) - 1)

`endif

// ### hdl/twbs_pkg.sv
package twbs_pkg;

    typedef enum logic [4:0] {
        ST_IDLE    = 5'h00,
        ST_M_STA_A = 5'h01,
        ST_M_STA_B = 5'h02,
        ST_M_WAIT  = 5'h03,
        ST_M_BIT_L = 5'h04,
        ST_M_BIT_H = 5'h05,
        ST_M_ACK_L = 5'h06,
        ST_M_ACK_H = 5'h07,
        ST_M_RST_A = 5'h08,
        ST_M_RST_B = 5'h09,
        ST_M_STP_A = 5'h0a,
        ST_M_STP_B = 5'h0b,
        ST_M_STP_C = 5'h0c,
        ST_S_RECV  = 5'h0d,
        ST_S_ACK   = 5'h0e,
        ST_S_WAIT  = 5'h0f,
        ST_S_SEND  = 5'h10,
        ST_S_SACK  = 5'h11
    } twbs_state_t;

    typedef enum logic [7:0] {
        SC_NONE = 8'h00, SC_STA  = 8'h08, SC_RSTA = 8'h10, SC_AW_A = 8'h18,
        SC_AW_N = 8'h20, SC_TX_A = 8'h28, SC_TX_N = 8'h30, SC_ARB  = 8'h38,
        SC_AR_A = 8'h40, SC_AR_N = 8'h48, SC_RX_A = 8'h50, SC_RX_N = 8'h58,
        SC_SW   = 8'h60, SC_GC   = 8'h70, SC_SR_A = 8'h80, SC_SR_N = 8'h88,
        SC_GR_A = 8'h90, SC_GR_N = 8'h98, SC_SSTP = 8'ha0, SC_SR   = 8'ha8,
        SC_ST_A = 8'hb8, SC_ST_N = 8'hc0, SC_ST_L = 8'hc8
    } twbs_code_t;

    typedef struct packed {
        twbs_state_t st;
        logic [7:0]  status;
        logic        irq;
        logic        c_start;
        logic        c_stop;
        logic        c_ack;
        logic        c_fast;
        logic        c_mstr;
        logic        c_filen;
        logic        broadcast_multimaster_enable;
        logic        own_address_match_enable;
        logic [6:0]  own;
        logic [7:0]  div;
        logic [7:0]  txbuf;
        logic [7:0]  rxbuf;
        logic [7:0]  sh;
        logic [3:0]  bitcnt;
        logic [7:0]  cnt;
        logic        sda_drv;
        logic        scl_drv;
        logic        first;
        logic        dir;
        logic        m_rx;
        logic        acked;
        logic        owner;
        logic        busy;
        logic        slv_act;
        logic        slv_gc;
        logic        slv_last;
        logic [7:0]  rdata;
        logic [1:0]  scl_m;
        logic [1:0]  sda_m;
        logic        scl_q;
        logic        sda_q;
    } twbs_state_s_t;

endpackage

// ### hdl/twbs_engine.sv
`timescale 1ns/100ps
`default_nettype none
`include "twbs_params.svh"

module twbs_engine
    import twbs_pkg::*;
(
    input  wire logic       i_clock,        // system clock
    input  wire logic       i_rst,          // async reset, active high
    input  wire logic [7:0] i_sfr_addr,     // register address
    input  wire logic       i_sfr_wr,       // write strobe
    input  wire logic       i_sfr_rd,       // read strobe
    input  wire logic [7:0] i_sfr_wdata,    // write data
    output logic      [7:0] o_sfr_rdata,    // read data, cycle after strobe
    output logic            o_status_irq,   // status pending
    input  wire logic       i_scl,          // clock line level
    output logic            o_scl,          // clock line drive value
    output logic            o_scl_oe_n,     // clock line drive, low = driving
    input  wire logic       i_sda,          // data line level
    output logic            o_sda,          // data line drive value
    output logic            o_sda_oe_n      // data line drive, low = driving
);

    localparam logic [7:0] DIV_STD  = 8'(`TWBS_DIV_STD);
    localparam logic [7:0] DIV_FAST = 8'(`TWBS_DIV_FAST);

    twbs_state_s_t r_ff;
    twbs_state_s_t nxt_r;

    logic       scl;
    logic       sda;
    logic       scl_rise;
    logic       scl_fall;
    logic       sta_det;
    logic       stp_det;
    logic       tick;
    logic       wr_ctrl;
    logic       wr_data;
    logic       rd_data;
    logic       in_master;
    logic       ld;
    logic [7:0] code;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        nxt_r = r_ff;
        ld    = 1'b0;
        code  = SC_NONE;

        // line synchronisers, stage 0 only feeds stage 1
        nxt_r.scl_m = {r_ff.scl_m[0], i_scl};
        nxt_r.sda_m = {r_ff.sda_m[0], i_sda};
        scl         = r_ff.scl_m[1];
        sda         = r_ff.sda_m[1];
        nxt_r.scl_q = scl;
        nxt_r.sda_q = sda;
        scl_rise    = scl & ~r_ff.scl_q;
        scl_fall    = ~scl & r_ff.scl_q;
        sta_det     = scl & r_ff.scl_q & r_ff.sda_q & ~sda;
        stp_det     = scl & r_ff.scl_q & ~r_ff.sda_q & sda;
        if (sta_det)
            nxt_r.busy = 1'b1;
        if (stp_det)
            nxt_r.busy = 1'b0;

        wr_ctrl = i_sfr_wr && (i_sfr_addr == `TWBS_ADDR_CTRL);
        wr_data = i_sfr_wr && (i_sfr_addr == `TWBS_ADDR_DATA);
        rd_data = i_sfr_rd && (i_sfr_addr == `TWBS_ADDR_DATA);

        // half-period timer; a stretched low phase freezes it
        tick = (r_ff.cnt == 8'h00);
        if (r_ff.scl_drv | scl) begin
            nxt_r.cnt = tick ? r_ff.div : r_ff.cnt - 8'h01;
        end

        // ----------------------------------------
        // register writes
        // ----------------------------------------
        if (wr_ctrl) begin
            nxt_r.c_start = i_sfr_wdata[`TWBS_CTRL_START];
            nxt_r.c_stop  = i_sfr_wdata[`TWBS_CTRL_STOP];
            nxt_r.c_ack   = i_sfr_wdata[`TWBS_CTRL_ACK];
            nxt_r.c_fast  = i_sfr_wdata[`TWBS_CTRL_FAST];
            nxt_r.c_mstr  = i_sfr_wdata[`TWBS_CTRL_MSTR];
            nxt_r.c_filen = i_sfr_wdata[`TWBS_CTRL_FILEN];
            // preset only on a change, so a later divisor write sticks
            if (i_sfr_wdata[`TWBS_CTRL_FAST] != r_ff.c_fast) begin
                nxt_r.div = i_sfr_wdata[`TWBS_CTRL_FAST] ? DIV_FAST : DIV_STD;
            end
        end
        if (wr_data)
            nxt_r.txbuf = i_sfr_wdata;
        if (i_sfr_wr && (i_sfr_addr == `TWBS_ADDR_GM))
            nxt_r.broadcast_multimaster_enable = i_sfr_wdata[`TWBS_GM_EN];
        if (i_sfr_wr && (i_sfr_addr == `TWBS_ADDR_STAT)) begin
            if (r_ff.c_mstr) begin
                nxt_r.div = i_sfr_wdata;
            end else begin
                nxt_r.own_address_match_enable = i_sfr_wdata[`TWBS_SA_EN];
                nxt_r.own = i_sfr_wdata[6:0];
            end
        end

        // ----------------------------------------
        // register reads
        // ----------------------------------------
        if (i_sfr_rd) begin
            unique case (i_sfr_addr)
                `TWBS_ADDR_CTRL: nxt_r.rdata = {r_ff.c_start, r_ff.c_stop, r_ff.c_ack, 1'b0,
                                                r_ff.c_fast, r_ff.c_mstr, 1'b0, r_ff.c_filen};
                `TWBS_ADDR_DATA: nxt_r.rdata = r_ff.rxbuf;
                `TWBS_ADDR_STAT: nxt_r.rdata = {r_ff.status[7:3], 3'b000};
                `TWBS_ADDR_SRST: nxt_r.rdata = `TWBS_RST_SRST;
                default:         nxt_r.rdata = 8'h00;
            endcase
            if (i_sfr_addr == `TWBS_ADDR_STAT)
                nxt_r.irq = 1'b0;
        end

        in_master = (r_ff.st != ST_IDLE) && (r_ff.st < ST_S_RECV);

        // ----------------------------------------
        // slave-side bus conditions
        // ----------------------------------------
        if (!in_master && (sta_det || stp_det)) begin
            if (r_ff.slv_act) begin
                ld   = 1'b1;
                code = SC_SSTP;
            end
            nxt_r.slv_act = 1'b0;
            nxt_r.sda_drv = 1'b0;
            nxt_r.scl_drv = 1'b0;
            nxt_r.bitcnt  = 4'h0;
            nxt_r.first   = 1'b1;
            nxt_r.st      = sta_det ? ST_S_RECV : ST_IDLE;
        end else begin
            unique case (r_ff.st)
                ST_IDLE: begin
                    nxt_r.sda_drv = 1'b0;
                    nxt_r.scl_drv = 1'b0;
                    if (r_ff.c_mstr && r_ff.c_start && (!r_ff.busy || r_ff.owner)) begin
                        nxt_r.sda_drv = 1'b1;
                        nxt_r.cnt     = r_ff.div;
                        nxt_r.st      = ST_M_STA_A;
                    end else if (r_ff.c_mstr && r_ff.c_stop && !r_ff.busy) begin
                        nxt_r.c_stop = wr_ctrl && i_sfr_wdata[`TWBS_CTRL_STOP];
                    end
                end

                // ---- master ----
                ST_M_STA_A: begin
                    if (tick) begin
                        nxt_r.scl_drv = 1'b1;
                        nxt_r.st      = ST_M_STA_B;
                    end
                end
                ST_M_STA_B: begin
                    if (tick) begin
                        ld            = 1'b1;
                        code          = r_ff.owner ? SC_RSTA : SC_STA;
                        nxt_r.owner   = 1'b1;
                        // set wins: a start written in this very cycle survives
                        nxt_r.c_start = wr_ctrl && i_sfr_wdata[`TWBS_CTRL_START];
                        nxt_r.first   = 1'b1;
                        nxt_r.st      = ST_M_WAIT;
                    end
                end
                ST_M_WAIT: begin
                    nxt_r.sda_drv = 1'b0;
                    nxt_r.cnt     = r_ff.div;
                    nxt_r.bitcnt  = 4'h0;
                    if (r_ff.c_stop) begin
                        nxt_r.sda_drv = 1'b1;
                        nxt_r.st      = ST_M_STP_A;
                    end else if (r_ff.c_start) begin
                        nxt_r.st = ST_M_RST_A;
                    end else if (wr_data) begin
                        nxt_r.sh   = i_sfr_wdata;
                        nxt_r.m_rx = 1'b0;
                        if (r_ff.first)
                            nxt_r.dir = i_sfr_wdata[0];
                        nxt_r.st = ST_M_BIT_L;
                    end else if (rd_data && r_ff.dir && !r_ff.first) begin
                        nxt_r.m_rx = 1'b1;
                        nxt_r.st   = ST_M_BIT_L;
                    end
                end
                ST_M_BIT_L: begin
                    nxt_r.sda_drv = !r_ff.m_rx && !r_ff.sh[7];
                    if (tick) begin
                        nxt_r.scl_drv = 1'b0;
                        nxt_r.st      = ST_M_BIT_H;
                    end
                end
                ST_M_BIT_H: begin
                    if (tick) begin
                        if (!r_ff.m_rx && r_ff.sh[7] && !sda) begin
                            // lost the bus: let go and return to idle
                            ld            = 1'b1;
                            code          = SC_ARB;
                            nxt_r.sda_drv = 1'b0;
                            nxt_r.owner   = 1'b0;
                            nxt_r.st      = ST_IDLE;
                        end else begin
                            nxt_r.sh      = {r_ff.sh[6:0], sda};
                            nxt_r.bitcnt  = r_ff.bitcnt + 4'h1;
                            nxt_r.scl_drv = 1'b1;
                            nxt_r.st      = (r_ff.bitcnt == 4'h7) ? ST_M_ACK_L : ST_M_BIT_L;
                        end
                    end
                end
                ST_M_ACK_L: begin
                    nxt_r.sda_drv = r_ff.m_rx && r_ff.c_ack;
                    if (tick) begin
                        nxt_r.scl_drv = 1'b0;
                        nxt_r.st      = ST_M_ACK_H;
                    end
                end
                ST_M_ACK_H: begin
                    if (tick) begin
                        ld = 1'b1;
                        if (r_ff.first) begin
                            if (r_ff.dir)
                                code = !sda ? SC_AR_A : SC_AR_N;
                            else
                                code = !sda ? SC_AW_A : SC_AW_N;
                        end else if (r_ff.m_rx) begin
                            code        = r_ff.c_ack ? SC_RX_A : SC_RX_N;
                            nxt_r.rxbuf = r_ff.sh;
                        end else begin
                            code = !sda ? SC_TX_A : SC_TX_N;
                        end
                        nxt_r.scl_drv = 1'b1;
                        nxt_r.first   = 1'b0;
                        nxt_r.st      = ST_M_WAIT;
                    end
                end
                ST_M_RST_A: begin
                    if (tick) begin
                        nxt_r.scl_drv = 1'b0;
                        nxt_r.st      = ST_M_RST_B;
                    end
                end
                ST_M_RST_B: begin
                    if (tick) begin
                        nxt_r.sda_drv = 1'b1;
                        nxt_r.st      = ST_M_STA_A;
                    end
                end
                ST_M_STP_A: begin
                    if (tick) begin
                        nxt_r.scl_drv = 1'b0;
                        nxt_r.st      = ST_M_STP_B;
                    end
                end
                ST_M_STP_B: begin
                    if (tick) begin
                        nxt_r.sda_drv = 1'b0;
                        nxt_r.st      = ST_M_STP_C;
                    end
                end
                ST_M_STP_C: begin
                    if (tick) begin
                        nxt_r.owner  = 1'b0;
                        nxt_r.c_stop = wr_ctrl && i_sfr_wdata[`TWBS_CTRL_STOP];
                        nxt_r.st     = ST_IDLE;
                    end
                end

                // ---- slave ----
                ST_S_RECV: begin
                    if (scl_rise) begin
                        nxt_r.sh     = {r_ff.sh[6:0], sda};
                        nxt_r.bitcnt = r_ff.bitcnt + 4'h1;
                    end else if (scl_fall && r_ff.bitcnt == 4'h8) begin
                        if (r_ff.first) begin
                            if (r_ff.own_address_match_enable && r_ff.sh[7:1] == r_ff.own) begin
                                nxt_r.sda_drv = 1'b1;
                                nxt_r.dir     = r_ff.sh[0];
                                nxt_r.slv_gc  = 1'b0;
                                nxt_r.st      = ST_S_ACK;
                            end else if (r_ff.broadcast_multimaster_enable && r_ff.sh == 8'h00) begin
                                nxt_r.sda_drv = 1'b1;
                                nxt_r.dir     = 1'b0;
                                nxt_r.slv_gc  = 1'b1;
                                nxt_r.st      = ST_S_ACK;
                            end else begin
                                nxt_r.st = ST_IDLE;
                            end
                        end else begin
                            nxt_r.rxbuf   = r_ff.sh;
                            nxt_r.sda_drv = r_ff.c_ack;
                            nxt_r.acked   = r_ff.c_ack;
                            nxt_r.st      = ST_S_ACK;
                        end
                    end
                end
                ST_S_ACK: begin
                    if (scl_fall) begin
                        ld = 1'b1;
                        if (r_ff.first)
                            code = r_ff.slv_gc ? SC_GC : (r_ff.dir ? SC_SR : SC_SW);
                        else if (r_ff.slv_gc)
                            code = r_ff.acked ? SC_GR_A : SC_GR_N;
                        else
                            code = r_ff.acked ? SC_SR_A : SC_SR_N;
                        nxt_r.sda_drv = 1'b0;
                        nxt_r.slv_act = 1'b1;
                        nxt_r.first   = 1'b0;
                        nxt_r.scl_drv = 1'b1;
                        nxt_r.st      = ST_S_WAIT;
                    end
                end
                ST_S_WAIT: begin
                    // first bit set up while the clock is still held
                    nxt_r.sda_drv = r_ff.dir && !r_ff.txbuf[7];
                    nxt_r.bitcnt  = 4'h0;
                    if (wr_ctrl && i_sfr_wdata[`TWBS_CTRL_SCLS]) begin
                        nxt_r.scl_drv  = 1'b0;
                        nxt_r.sh       = r_ff.txbuf;
                        nxt_r.slv_last = !r_ff.c_ack;
                        nxt_r.st       = r_ff.dir ? ST_S_SEND : ST_S_RECV;
                    end
                end
                ST_S_SEND: begin
                    if (scl_fall) begin
                        nxt_r.bitcnt = r_ff.bitcnt + 4'h1;
                        if (r_ff.bitcnt == 4'h7) begin
                            nxt_r.sda_drv = 1'b0;
                            nxt_r.st      = ST_S_SACK;
                        end else begin
                            nxt_r.sh      = {r_ff.sh[6:0], 1'b0};
                            nxt_r.sda_drv = !r_ff.sh[6];
                        end
                    end
                end
                ST_S_SACK: begin
                    if (scl_rise)
                        nxt_r.acked = !sda;
                    if (scl_fall) begin
                        ld = 1'b1;
                        if (r_ff.slv_last)
                            code = SC_ST_L;
                        else
                            code = r_ff.acked ? SC_ST_A : SC_ST_N;
                        if (r_ff.slv_last || !r_ff.acked) begin
                            nxt_r.st = ST_IDLE;
                        end else begin
                            nxt_r.scl_drv = 1'b1;
                            nxt_r.st      = ST_S_WAIT;
                        end
                    end
                end
            endcase
        end

        // set wins over a read clear in the same cycle
        if (ld) begin
            nxt_r.status = code;
            nxt_r.irq    = 1'b1;
        end

        // ----------------------------------------
        // controller soft reset
        // ----------------------------------------
        if (i_sfr_wr && (i_sfr_addr == `TWBS_ADDR_SRST)) begin
            nxt_r.st      = ST_IDLE;
            nxt_r.cnt     = 8'h00;
            nxt_r.bitcnt  = 4'h0;
            nxt_r.sda_drv = 1'b0;
            nxt_r.scl_drv = 1'b0;
            nxt_r.owner   = 1'b0;
            nxt_r.busy    = 1'b0;
            nxt_r.slv_act = 1'b0;
            nxt_r.first   = 1'b0;
            nxt_r.c_start = 1'b0;
            nxt_r.c_stop  = 1'b0;
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            r_ff        <= '0;
            r_ff.status <= `TWBS_RST_STAT;
            r_ff.div    <= DIV_STD;
            // lines idle high; a zero here would fake an edge after reset
            r_ff.scl_m  <= 2'b11;
            r_ff.sda_m  <= 2'b11;
            r_ff.scl_q  <= 1'b1;
            r_ff.sda_q  <= 1'b1;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // open-drain lines only ever pull low
    assign o_scl        = 1'b0;
    assign o_sda        = 1'b0;
    assign o_scl_oe_n   = !r_ff.scl_drv;
    assign o_sda_oe_n   = !r_ff.sda_drv;
    assign o_sfr_rdata  = r_ff.rdata;
    assign o_status_irq = r_ff.irq;

endmodule

`default_nettype wire

// ### verif/twbs_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module twbs_asserts (
    input wire logic       i_clock,      // clock
    input wire logic       i_rst,        // reset
    input wire logic [7:0] i_sfr_addr,   // address
    input wire logic       i_sfr_wr,     // write
    input wire logic       i_sfr_rd,     // read
    input wire logic [7:0] i_sfr_wdata,  // write data
    input wire logic [7:0] o_sfr_rdata,  // read data
    input wire logic       o_status_irq, // pending
    input wire logic       i_scl,        // clock line
    input wire logic       i_sda,        // data line
    input wire logic       o_scl_oe_n,   // clock pull
    input wire logic       o_sda_oe_n    // data pull
);
    // ----------------
    // port checks
    // ----------------
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    wire logic [7:0] a = i_sfr_addr;
    wire logic go = i_sfr_wr && a == 8'h9a && i_sfr_wdata[7] && i_sfr_wdata[2] && i_scl && i_sda;
    a_status_low: assert property (i_sfr_rd && a == 8'h9d |=> o_sfr_rdata[2:0] == 3'h0)
        else $error("status low bits set");
    a_srst_read: assert property (i_sfr_rd && a == 8'h9e |=> o_sfr_rdata == 8'h80)
        else $error("soft reset read wrong");
    a_rdata_hold: assert property (!i_sfr_rd |=> $stable(o_sfr_rdata))
        else $error("read data moved");
    a_srst_idle: assert property (i_sfr_wr && a == 8'h9e |-> ##[1:2] o_scl_oe_n && o_sda_oe_n)
        else $error("lines held after soft reset");
    a_start_sent: assert property (go |-> ##[1:12] !o_sda_oe_n)
        else $error("no start");
    a_start_flag: assert property ($fell(o_sda_oe_n) && i_scl |-> ##[1:600] o_status_irq)
        else $error("no status after start");
    // divisor the test writes is 3 and the presets are larger, so each phase spans at least 4 clocks
    a_scl_low: assert property ($fell(o_scl_oe_n) |-> (!o_scl_oe_n) [*4])
        else $error("clock low too short");
    a_scl_high: assert property ($rose(o_scl_oe_n) |-> o_scl_oe_n [*4])
        else $error("clock high too short");
    c_status: cover property ($rose(o_status_irq));
    c_start: cover property (go);
    c_srst: cover property (i_sfr_wr && a == 8'h9e);
endmodule
`default_nettype wire

// ### verif/twbs_bus_slave.sv
`timescale 1ns/100ps
`default_nettype none
module twbs_bus_slave #(
    parameter logic [6:0] ADR = 7'h2a, // address answered
    parameter logic [7:0] DAT = 8'h5a  // byte sent on reads
) (
    input  wire logic i_scl, // clock line
    input  wire logic i_sda, // data line
    output logic      o_low  // pulls data low
);
    // ----------------
    // byte engine, released unless pulling so pull-up shows
    // ----------------
    logic [7:0] sh = 8'h00;
    int         n = -1;
    logic       adr = 1'b0, act = 1'b0, rd = 1'b0;
    initial o_low = 1'b0;
    always @(negedge i_sda) if (i_scl) begin
        n = 0;
        adr = 1'b1;
    end
    always @(posedge i_sda) if (i_scl) n = -1;
    always @(posedge i_scl) if (n >= 0) begin
        if (n < 8) sh = {sh[6:0], i_sda};
        else if (rd && !adr && i_sda) n = -1; // master nack ends the read
        if (n >= 0) n++;
    end
    always @(negedge i_scl) begin
        o_low = 1'b0;
        if (n == 8 && adr) begin
            act = sh[7:1] == ADR;
            rd = sh[0];
        end
        // all-ones data is refused so the nack path gets exercised
        if (n == 8) o_low = act && !(rd && !adr) && !(!adr && sh == 8'hff);
        if (n == 9) begin
            n = 0;
            adr = 1'b0;
        end
        if (n >= 0 && n < 8 && act && rd && !adr) o_low = !DAT[7 - n];
    end
endmodule
`default_nettype wire

// ### verif/two_wire_bus_status_engine_test.sv
`timescale 1ns/100ps
`default_nettype none
module two_wire_bus_status_engine_test;
    localparam logic [6:0] ADR = 7'h2a;
    localparam logic [7:0] DAT = 8'h5a;
    logic            i_clock = 1'b0;
    logic            i_rst = 1'b1;
    logic            jam = 1'b0;
    logic            i_sfr_wr = 1'b0;
    logic            i_sfr_rd = 1'b0;
    logic [7:0]      i_sfr_addr = 8'h00;
    logic [7:0]      i_sfr_wdata = 8'h00;
    wire logic [7:0] o_sfr_rdata;
    wire logic       o_status_irq, o_scl, o_scl_oe_n, o_sda, o_sda_oe_n, low;
    wire logic       i_scl = o_scl_oe_n | o_scl;
    wire logic       i_sda = (o_sda_oe_n | o_sda) & !low & !jam;
    int              fails = 0;
    int              samples_checked = 0;
    twbs_engine dut (.i_clock, .i_rst, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata,
        .o_sfr_rdata, .o_status_irq, .i_scl, .o_scl, .o_scl_oe_n, .i_sda, .o_sda, .o_sda_oe_n);
    twbs_bus_slave #(.ADR(ADR), .DAT(DAT)) peer (.i_scl, .i_sda, .o_low(low));
    initial forever #10 i_clock = !i_clock;
    // ----------------
    // access tasks
    // ----------------
    task automatic chk(input logic [7:0] g, e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wrap_up();
        if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // read checks d unless it is all unknown; c nonzero waits for that status
    task automatic op(input logic w, input logic [7:0] a, d, c);
        int k = 0;
        @(posedge i_clock);
        #1;
        i_sfr_addr = a;
        i_sfr_wdata = w ? d : 8'h00;
        i_sfr_wr = w;
        i_sfr_rd = !w;
        @(posedge i_clock);
        #1;
        i_sfr_wr = 1'b0;
        i_sfr_rd = 1'b0;
        if (!w && d !== 8'hxx) chk(o_sfr_rdata, d);
        while (c !== 8'h00 && o_status_irq !== 1'b1 && k < 2000) begin
            @(posedge i_clock);
            #1;
            k++;
        end
        if (k == 2000) begin
            fails++;
            wrap_up();
        end else if (c !== 8'h00) begin
            op(1'b0, 8'h9d, c, 8'h00);
            chk({7'h0, o_status_irq}, 8'h00);
        end
    endtask
    initial begin
        repeat (8) @(posedge i_clock);
        #1;
        i_rst = 1'b0;
        op(1'b0, 8'h9e, 8'h80, 8'h00);
        op(1'b0, 8'h9d, 8'h00, 8'h00);
        op(1'b0, 8'h9c, 8'h00, 8'h00);
        op(1'b0, 8'ha0, 8'h00, 8'h00);
        op(1'b1, 8'h9a, 8'h04, 8'h00);
        op(1'b1, 8'h9d, 8'h03, 8'h00);
        op(1'b1, 8'h9a, 8'h84, 8'h08);
        op(1'b1, 8'h9b, {ADR, 1'b0}, 8'h18);
        op(1'b1, 8'h9b, 8'h3c, 8'h28);
        op(1'b1, 8'h9b, 8'hff, 8'h30);
        op(1'b1, 8'h9a, 8'h84, 8'h10);
        op(1'b1, 8'h9b, {ADR, 1'b1}, 8'h40);
        op(1'b1, 8'h9a, 8'h24, 8'h00);
        op(1'b0, 8'h9b, 8'hxx, 8'h50);
        op(1'b1, 8'h9a, 8'h04, 8'h00);
        op(1'b0, 8'h9b, DAT, 8'h58);
        op(1'b1, 8'h9a, 8'h84, 8'h10);
        op(1'b1, 8'h9b, {ADR + 7'h1, 1'b0}, 8'h20);
        // a second driver holds data low, so the first one sent loses the bus
        jam = 1'b1;
        op(1'b1, 8'h9b, 8'hff, 8'h38);
        jam = 1'b0;
        op(1'b1, 8'h9e, 8'h00, 8'h00);
        repeat (2) @(posedge i_clock);
        #1;
        chk({4'h0, o_scl, o_sda, o_scl_oe_n, o_sda_oe_n}, 8'h03);
        op(1'b0, 8'h9a, 8'h04, 8'h00);
        op(1'b1, 8'h9a, 8'h84, 8'h08);
        op(1'b1, 8'h9b, {ADR + 7'h1, 1'b1}, 8'h48);
        op(1'b1, 8'h9e, 8'h00, 8'h00);
        wrap_up();
    end
endmodule
bind twbs_engine twbs_asserts u_chk (.i_clock, .i_rst, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd,
    .i_sfr_wdata, .o_sfr_rdata, .o_status_irq, .i_scl, .i_sda, .o_scl_oe_n, .o_sda_oe_n);
`default_nettype wire
